// ===== bp_interp_pkg.sv
// Package of constants and types for the bit pattern interpolator
package bp_interp_pkg;
   // Host bus word register indices (16-bit bus)
   localparam logic [2:0] ADDR_CMD = 3'h0;
   localparam logic [2:0] ADDR_AX1P = 3'h2;
   localparam logic [2:0] ADDR_AX1M = 3'h3;
   localparam logic [2:0] ADDR_AX2P = 3'h4;
   localparam logic [2:0] ADDR_AX2M = 3'h5;
   localparam logic [2:0] ADDR_AX3P = 3'h6;
   localparam logic [2:0] ADDR_AX3M = 3'h7;
   // Command codes written to the command register
   localparam logic [7:0] CMD_BP2 = 8'h34;
   localparam logic [7:0] CMD_BP3 = 8'h35;
   localparam logic [7:0] CMD_WR_EN = 8'h36;
   localparam logic [7:0] CMD_WR_DIS = 8'h37;
   localparam logic [7:0] CMD_PUSH = 8'h38;
   localparam logic [7:0] CMD_CLEAR = 8'h39;
   localparam logic [7:0] CMD_IRQ_CLR = 8'h3D;
   // Field positions
   localparam int DEPTH_LSB = 13;
   localparam int BUSY_BIT = 8;
   localparam int IRQ_EN_BIT = 15;
   // Reset and count values
   localparam logic [15:0] PATTERN_RESET = 16'h0000;
   localparam logic [1:0] DEPTH_RESET = 2'h0;
   localparam logic [1:0] DEPTH_FULL = 2'h3;
   localparam logic [3:0] BIT_LAST = 4'hF;
   localparam logic [3:0] BIT_RESET = 4'h0;
   // Fastest pattern step rate and its least period in clock cycles
   localparam int CLOCK_HZ = 100_000_000;
   localparam int MAX_STEP_HZ = 4_000_000;
   localparam int MIN_STEP_CYCLES = (CLOCK_HZ + MAX_STEP_HZ - 1) / MAX_STEP_HZ;
   localparam int NUM_AXES = 3;
   localparam int QUEUE_DEPTH = 16;

   // Plus and minus pattern words of one stage for all axes
   typedef struct packed {
      logic [NUM_AXES-1:0][15:0] plus;
      logic [NUM_AXES-1:0][15:0] minus;
   } stage_s;

   // Host write transaction
   typedef struct packed {
      logic [2:0] addr;
      logic [15:0] data;
   } host_wr_s;

   // Drive engine states
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } run_state_e;
endpackage

// ===== bp_fifo.sv
// Parameterised valid/ready FIFO in flip-flops
`timescale 1ns/100ps
`default_nettype none
module bp_fifo #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   // Storage and pointers
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   // Ready is registered so the port comes straight from a flip-flop
   logic ready_reg, ready_next;
   logic push, pop;

   // Handshake and pointer arithmetic
   always_comb begin
      push = in_valid && ready_reg;
      pop = (cnt_reg != '0) && out_ready;
      wr_next = push ? wr_reg + AW'(1) : wr_reg;
      rd_next = pop ? rd_reg + AW'(1) : rd_reg;
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      ready_next = (cnt_next != (AW+1)'(DEPTH));
      in_ready = ready_reg;
      out_valid = (cnt_reg != '0);
      out_data = mem_reg[rd_reg];
   end

   // Registers
   always_ff @(posedge clock) begin
      if (reset) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         ready_reg <= 1'b1;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
         ready_reg <= ready_next;
      end
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ===== bit_pattern_interpolator.sv
// Bit pattern interpolation unit: pattern queue and per-axis step output
`timescale 1ns/100ps
`default_nettype none
module bit_pattern_interpolator (
   input wire logic clock,
   input wire logic reset,
   input wire logic host_wr_valid,
   output logic host_wr_ready,
   input wire logic [2:0] host_addr,
   input wire logic [15:0] host_wdata,
   input wire logic [15:0] axis_assign_mode_word,
   input wire logic main_axis_pulse,
   input wire logic stop_cmd,
   input wire logic [2:0] limit_plus,
   input wire logic [2:0] limit_minus,
   output logic [15:0] main_status_word,
   output logic [2:0] step_plus,
   output logic [2:0] step_minus,
   output logic irq_out_n,
   output logic irq_out_oe,
   output logic [15:0] axis_write_word_two
);
   // Host writes are buffered in the FIFO before decoding
   logic fifo_valid, fifo_ready;
   bp_interp_pkg::host_wr_s fifo_in, wr;
   assign fifo_in = '{addr: host_addr, data: host_wdata};
   assign fifo_ready = 1'b1;

   bp_fifo #(.WIDTH(19), .DEPTH(bp_interp_pkg::QUEUE_DEPTH)) wr_fifo (
      .clock(clock),
      .reset(reset),
      .in_valid(host_wr_valid),
      .in_ready(host_wr_ready),
      .in_data(fifo_in),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(wr)
   );

   // Pin inputs pass two flip-flops first
   logic [7:0] sync1_reg, sync2_reg;
   always_ff @(posedge clock) begin
      if (reset) begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
      end else begin
         sync1_reg <= {main_axis_pulse, stop_cmd, limit_plus, limit_minus};
         sync2_reg <= sync1_reg;
      end
   end
   logic pulse_s, stop_s;
   logic [2:0] lim_p_s, lim_m_s;
   assign {pulse_s, stop_s, lim_p_s, lim_m_s} = sync2_reg;

   // Pattern staging words, shift stage, two holding stages
   bp_interp_pkg::stage_s write_reg, write_next;
   bp_interp_pkg::stage_s shift_reg, shift_next;
   bp_interp_pkg::stage_s hold1_reg, hold1_next;
   bp_interp_pkg::stage_s hold2_reg, hold2_next;
   // Queue depth count and bit position within the shift stage
   logic [1:0] depth_reg, depth_next;
   logic [3:0] bit_reg, bit_next;
   // Pattern write enable and three-axis mode
   logic wr_en_reg, wr_en_next;
   logic three_reg, three_next;
   // Previous pulse level for edge detection
   logic pulse_d_reg;
   // Pending refill interrupt and ordinary word two
   logic irq_reg, irq_next;
   logic [15:0] word_two_reg, word_two_next;
   // Drive pulse outputs, one cycle each
   logic [2:0] sp_reg, sp_next, sm_reg, sm_next;
   // Drive engine state
   bp_interp_pkg::run_state_e state_reg, state_next;

   // Command decode helper
   function automatic logic is_cmd(input bp_interp_pkg::host_wr_s w,
                                   input logic v, input logic [7:0] c);
      is_cmd = v && w.addr == bp_interp_pkg::ADDR_CMD && w.data[7:0] == c;
   endfunction

   // Next-state logic of queue, drive and interrupt
   always_comb begin
      logic step, any_limit, last_bit, stop_drive, push;
      write_next = write_reg;
      shift_next = shift_reg;
      hold1_next = hold1_reg;
      hold2_next = hold2_reg;
      depth_next = depth_reg;
      bit_next = bit_reg;
      wr_en_next = wr_en_reg;
      three_next = three_reg;
      irq_next = irq_reg;
      word_two_next = word_two_reg;
      state_next = state_reg;
      sp_next = 3'h0;
      sm_next = 3'h0;
      // Limits on participating axes block both directions
      any_limit = |(lim_p_s[1:0] | lim_m_s[1:0])
                  | (three_reg & (lim_p_s[2] | lim_m_s[2]));
      // One step per rising pulse edge; needs one high and one low cycle
      step = state_reg == bp_interp_pkg::ST_RUN && pulse_s
             && !pulse_d_reg;
      last_bit = bit_reg == bp_interp_pkg::BIT_LAST;
      stop_drive = 1'b0;
      push = 1'b0;
      // Shared address writes: pattern words or ordinary word two
      if (fifo_valid && wr.addr != bp_interp_pkg::ADDR_CMD) begin
         if (wr_en_reg) begin
            unique case (wr.addr)
               bp_interp_pkg::ADDR_AX1P: write_next.plus[0] = wr.data;
               bp_interp_pkg::ADDR_AX1M: write_next.minus[0] = wr.data;
               bp_interp_pkg::ADDR_AX2P: write_next.plus[1] = wr.data;
               bp_interp_pkg::ADDR_AX2M: write_next.minus[1] = wr.data;
               bp_interp_pkg::ADDR_AX3P: write_next.plus[2] = wr.data;
               bp_interp_pkg::ADDR_AX3M: write_next.minus[2] = wr.data;
               default: ;
            endcase
         end else if (wr.addr == bp_interp_pkg::ADDR_AX1P) begin
            word_two_next = wr.data;
         end
      end
      // Commands
      if (is_cmd(wr, fifo_valid, bp_interp_pkg::CMD_WR_EN)) begin
         wr_en_next = 1'b1;
      end
      if (is_cmd(wr, fifo_valid, bp_interp_pkg::CMD_WR_DIS)) begin
         wr_en_next = 1'b0;
      end
      if (is_cmd(wr, fifo_valid, bp_interp_pkg::CMD_IRQ_CLR)) begin
         irq_next = 1'b0;
      end
      if (is_cmd(wr, fifo_valid, bp_interp_pkg::CMD_BP2)
          || is_cmd(wr, fifo_valid, bp_interp_pkg::CMD_BP3)) begin
         // Start or resume from whatever remains queued
         three_next = wr.data[0];
         // A start under an active stop or limit is refused
         if (depth_reg != bp_interp_pkg::DEPTH_RESET && !stop_s
             && !any_limit) begin
            state_next = bp_interp_pkg::ST_RUN;
         end
      end
      // Drive: one bit per main-axis basic pulse
      if (step) begin
         for (int a = 0; a < bp_interp_pkg::NUM_AXES; a++) begin
            if (a < 2 || three_reg) begin
               sp_next[a] = shift_reg.plus[a][0];
               sm_next[a] = shift_reg.minus[a][0];
            end
         end
         if (shift_reg.plus[0][0] && shift_reg.minus[0][0]) begin
            // End code on main axis drops everything queued
            sp_next[0] = 1'b0;
            sm_next[0] = 1'b0;
            depth_next = bp_interp_pkg::DEPTH_RESET;
            shift_next = '0;
            hold1_next = '0;
            hold2_next = '0;
            bit_next = bp_interp_pkg::BIT_RESET;
            stop_drive = 1'b1;
         end else if (last_bit) begin
            shift_next = hold1_reg;
            hold1_next = hold2_reg;
            hold2_next = '0;
            depth_next = depth_reg - 2'h1;
            bit_next = bp_interp_pkg::BIT_RESET;
            if (depth_reg == 2'h2) begin
               irq_next = 1'b1;
            end
            if (depth_reg == 2'h1) begin
               stop_drive = 1'b1;
            end
         end else begin
            for (int a = 0; a < bp_interp_pkg::NUM_AXES; a++) begin
               shift_next.plus[a] = {1'b0, shift_reg.plus[a][15:1]};
               shift_next.minus[a] = {1'b0, shift_reg.minus[a][15:1]};
            end
            bit_next = bit_reg + 4'h1;
         end
      end
      if (state_reg == bp_interp_pkg::ST_RUN && (stop_s || any_limit)) begin
         stop_drive = 1'b1;
         sp_next = 3'h0;
         sm_next = 3'h0;
      end
      // Push: load the stage selected by the depth count
      if (is_cmd(wr, fifo_valid, bp_interp_pkg::CMD_PUSH)
          && depth_next != bp_interp_pkg::DEPTH_FULL) begin
         push = 1'b1;
         unique case (depth_next)
            2'h0: shift_next = write_reg;
            2'h1: hold1_next = write_reg;
            2'h2: hold2_next = write_reg;
            default: ;
         endcase
         depth_next = depth_next + 2'h1;
         irq_next = 1'b0;
      end
      // Clear command empties every stage
      if (is_cmd(wr, fifo_valid, bp_interp_pkg::CMD_CLEAR)) begin
         shift_next = '0;
         hold1_next = '0;
         hold2_next = '0;
         depth_next = bp_interp_pkg::DEPTH_RESET;
         bit_next = bp_interp_pkg::BIT_RESET;
         // An empty queue cannot keep a drive running
         stop_drive = 1'b1;
      end
      if (stop_drive) begin
         state_next = bp_interp_pkg::ST_IDLE;
         irq_next = 1'b0;
      end
      // A refill event in the same cycle as a push or a clear is dropped
      if (step && last_bit && depth_reg == 2'h2 && !push && !stop_drive) begin
         irq_next = 1'b1;
      end
   end

   // State registers
   always_ff @(posedge clock) begin
      if (reset) begin
         write_reg <= '0;
         shift_reg <= '0;
         hold1_reg <= '0;
         hold2_reg <= '0;
         depth_reg <= bp_interp_pkg::DEPTH_RESET;
         bit_reg <= bp_interp_pkg::BIT_RESET;
         wr_en_reg <= 1'b0;
         three_reg <= 1'b0;
         pulse_d_reg <= 1'b0;
         irq_reg <= 1'b0;
         word_two_reg <= bp_interp_pkg::PATTERN_RESET;
         state_reg <= bp_interp_pkg::ST_IDLE;
         sp_reg <= 3'h0;
         sm_reg <= 3'h0;
      end else begin
         write_reg <= write_next;
         shift_reg <= shift_next;
         hold1_reg <= hold1_next;
         hold2_reg <= hold2_next;
         depth_reg <= depth_next;
         bit_reg <= bit_next;
         wr_en_reg <= wr_en_next;
         three_reg <= three_next;
         pulse_d_reg <= pulse_s;
         irq_reg <= irq_next;
         word_two_reg <= word_two_next;
         state_reg <= state_next;
         sp_reg <= sp_next;
         sm_reg <= sm_next;
      end
   end

   // Registered outputs
   logic [15:0] status_reg;
   logic irq_n_reg, irq_oe_reg;
   always_ff @(posedge clock) begin
      if (reset) begin
         status_reg <= 16'h0000;
         irq_n_reg <= 1'b1;
         irq_oe_reg <= 1'b0;
      end else begin
         status_reg <= 16'h0000;
         status_reg[bp_interp_pkg::DEPTH_LSB +: 2] <= depth_next;
         status_reg[bp_interp_pkg::BUSY_BIT] <=
            state_next == bp_interp_pkg::ST_RUN;
         irq_n_reg <= 1'b0;
         irq_oe_reg <= irq_next
            && axis_assign_mode_word[bp_interp_pkg::IRQ_EN_BIT];
      end
   end
   assign main_status_word = status_reg;
   assign step_plus = sp_reg;
   assign step_minus = sm_reg;
   assign irq_out_n = irq_n_reg;
   assign irq_out_oe = irq_oe_reg;
   assign axis_write_word_two = word_two_reg;
endmodule
`default_nettype wire

// ===== bpi_checker_props.sv
// Port-level timing checker for the bit pattern interpolator
`timescale 1ns/100ps
`default_nettype none
module bpi_checker (
   input wire logic clock,
   input wire logic reset,
   input wire logic [15:0] axis_assign_mode_word,
   input wire logic main_axis_pulse,
   input wire logic stop_cmd,
   input wire logic [2:0] limit_plus,
   input wire logic [2:0] limit_minus,
   input wire logic [15:0] main_status_word,
   input wire logic [2:0] step_plus,
   input wire logic [2:0] step_minus,
   input wire logic irq_out_n,
   input wire logic irq_out_oe
);
   // Status fields and any drive pulse at all
   wire logic [1:0] depth = main_status_word[14:13];
   wire logic busy = main_status_word[8];
   wire logic stepping = (step_plus | step_minus) != 3'h0;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   AST_RESET_CLEAR: assert property ($fell(reset) |-> main_status_word == 16'h0000)
      else $error("status not clear after reset");
   AST_DEPTH_MOVE: assert property ($changed(depth) && depth != 2'h0 |-> depth == $past(depth) + 2'h1 || depth == $past(depth) - 2'h1)
      else $error("depth jumped by more than one");
   AST_STEP_FROM_PIN: assert property (stepping |-> $past(main_axis_pulse, 3))
      else $error("drive pulse without main axis pulse");
   AST_STEP_ONE_CYCLE: assert property (stepping |=> !stepping)
      else $error("drive pulse longer than one cycle");
   AST_IDLE_QUIET: assert property ((!busy) [*6] |-> !stepping)
      else $error("drive pulse while idle");
   AST_IRQ_LOW: assert property (irq_out_oe |-> !irq_out_n
      && $past(axis_assign_mode_word[15]))
      else $error("interrupt output driven wrongly");
   AST_IRQ_RAISE: assert property (axis_assign_mode_word[15] && busy && $past(depth) == 2'h2 && depth == 2'h1 |-> ##[0:2] irq_out_oe)
      else $error("no interrupt on depth two to one");
   AST_IRQ_CAUSE: assert property ($rose(irq_out_oe) |-> depth == 2'h1 || $past(depth) == 2'h1)
      else $error("interrupt without depth one");
   AST_IRQ_IDLE: assert property ($fell(busy) |-> ##[0:2] !irq_out_oe)
      else $error("interrupt kept after drive end");
   AST_STOP_HALTS: assert property (stop_cmd [*5] |-> !busy)
      else $error("drive runs under stop");
   AST_LIMIT_HALTS: assert property (((limit_plus[1:0] | limit_minus[1:0]) != 2'h0) [*5] |-> !busy)
      else $error("drive runs under limit");
endmodule
bind bit_pattern_interpolator bpi_checker chk (
   .clock(clock),
   .reset(reset),
   .axis_assign_mode_word(axis_assign_mode_word),
   .main_axis_pulse(main_axis_pulse),
   .stop_cmd(stop_cmd),
   .limit_plus(limit_plus),
   .limit_minus(limit_minus),
   .main_status_word(main_status_word),
   .step_plus(step_plus),
   .step_minus(step_minus),
   .irq_out_n(irq_out_n),
   .irq_out_oe(irq_out_oe)
);
`default_nettype wire

// ===== motor_drive_model.sv
// Behavioural motor driver: issues basic pulses, gathers drive pulses
`timescale 1ns/100ps
`default_nettype none
module motor_drive_model (
   input wire logic clock,
   input wire logic [2:0] step_plus,
   input wire logic [2:0] step_minus,
   output logic main_axis_pulse,
   output logic [15:0] seen,
   output logic seen_valid
);
   // Idle pin low, no report
   initial begin
      main_axis_pulse = 1'b0;
      seen = 16'h0000;
      seen_valid = 1'b0;
   end
   // One basic pulse, then one report of all drive pulses it caused
   task automatic step();
      logic [5:0] acc;
      acc = 6'h00;
      main_axis_pulse = 1'b1;
      for (int i = 0; i < 12; i++) begin
         // Read the settled outputs just after each edge
         @(posedge clock);
         #1 acc = acc | {step_plus, step_minus};
         if (i == 2) main_axis_pulse = 1'b0;
      end
      seen = {10'h000, acc};
      seen_valid = 1'b1;
      @(posedge clock);
      #1 seen_valid = 1'b0;
      // Rest keeps the period above the fastest step rate
      repeat (bp_interp_pkg::MIN_STEP_CYCLES - 11) @(posedge clock);
      #1;
   endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the bit pattern interpolator
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clock, reset, host_wr_valid, host_wr_ready, main_axis_pulse;
   logic stop_cmd, irq_out_n, irq_out_oe, seen_valid;
   logic [2:0] host_addr, limit_plus, limit_minus, step_plus, step_minus;
   logic [15:0] host_wdata, axis_assign_mode_word, main_status_word;
   logic [15:0] axis_write_word_two, seen;
   int n_errors, checks_done, bi;
   logic run;
   logic [95:0] mq[$]; // Queued stages {p3,p2,p1,m3,m2,m1}
   logic [15:0] expq[$]; // Expected drive pulse reports
   bit_pattern_interpolator DUT (.clock(clock), .reset(reset),
      .host_wr_valid(host_wr_valid), .host_wr_ready(host_wr_ready),
      .host_addr(host_addr), .host_wdata(host_wdata),
      .axis_assign_mode_word(axis_assign_mode_word),
      .main_axis_pulse(main_axis_pulse), .stop_cmd(stop_cmd),
      .limit_plus(limit_plus), .limit_minus(limit_minus),
      .main_status_word(main_status_word), .step_plus(step_plus),
      .step_minus(step_minus), .irq_out_n(irq_out_n),
      .irq_out_oe(irq_out_oe), .axis_write_word_two(axis_write_word_two));
   motor_drive_model drv (.clock(clock), .step_plus(step_plus),
      .step_minus(step_minus), .main_axis_pulse(main_axis_pulse),
      .seen(seen), .seen_valid(seen_valid));
   // Free-running 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Compare and count
   task automatic check(input string what, input logic [15:0] s,
                        input logic [15:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, e, s);
      end
   endtask
   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Each drive pulse report is matched against the oldest note
   always @(posedge clock) begin
      if (seen_valid === 1'b1) begin
         // A report with no note behind it is a mismatch
         if (expq.size() == 0) expq.push_back(16'hFFFF);
         check("drive pulses", seen, expq.pop_front());
      end
   end
   // Host word write, held until the FIFO takes it; valid stays up
   // Both bytes of a pattern travel together in one 16-bit word
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      int n;
      host_addr = a;
      host_wdata = d;
      host_wr_valid = 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (host_wr_ready !== 1'b1 && n < 50);
      if (host_wr_ready !== 1'b1) n_errors++;
      #1;
   endtask
   // Release the bus and let n cycles pass
   task automatic idle(input int n);
      host_wr_valid = 1'b0;
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Command write, then time for status to settle
   task automatic cmd(input logic [7:0] c);
      wr(bp_interp_pkg::ADDR_CMD, {8'h00, c});
      idle(6);
   endtask
   // Depth and busy fields of the status word
   task automatic stat(input logic [1:0] d, input logic b);
      check("depth", {14'h0000, main_status_word[14:13]}, {14'h0000, d});
      check("busy", {15'h0000, main_status_word[8]}, {15'h0000, b});
   endtask
   // Write the six pattern words and push; full queue refuses
   task automatic push_set(input logic [95:0] w);
      for (int k = 0; k < 6; k++) begin
         wr(3'(k + 2), w[((k % 2) == 1 ? 0 : 48) + 16 * (k / 2) +: 16]);
      end
      cmd(bp_interp_pkg::CMD_PUSH);
      if (mq.size() < 3) mq.push_back(w);
   endtask
   // Random set; first axis never carries the end code
   task automatic push_rand(input logic three);
      logic [95:0] w;
      w = {$urandom, $urandom, $urandom};
      w[15:0] = w[15:0] & ~w[63:48];
      if (!three) begin
         w[95:80] = 16'h0000;
         w[47:32] = 16'h0000;
      end
      push_set(w);
   endtask
   // Basic pulses with the expected drive pulses noted beforehand
   task automatic pulses(input int n);
      logic [95:0] w;
      logic [5:0] e;
      repeat (n) begin
         w = (run && mq.size() != 0) ? mq[0] : 96'h0;
         for (int a = 0; a < 3; a++) begin
            e[3 + a] = w[48 + 16 * a + bi];
            e[a] = w[16 * a + bi];
         end
         expq.push_back({10'h000, e});
         if (run && mq.size() != 0) begin
            bi++;
            if (bi == 16) begin
               bi = 0;
               void'(mq.pop_front());
            end
         end
         drv.step();
      end
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      #400_000;
      n_errors++;
      finish_test();
   end
   // Main sequence
   initial begin
      reset = 1'b1;
      host_wr_valid = 1'b0;
      host_addr = 3'h0;
      host_wdata = 16'h0000;
      axis_assign_mode_word = 16'h8000;
      stop_cmd = 1'b0;
      limit_plus = 3'h0;
      limit_minus = 3'h0;
      n_errors = 0;
      checks_done = 0;
      bi = 0;
      run = 1'b1;
      void'($urandom(32'hB859));
      repeat (8) @(posedge clock);
      #1 reset = 1'b0;
      stat(2'h0, 1'b0);
      check("irq oe", {15'h0000, irq_out_oe}, 16'h0000);
      wr(bp_interp_pkg::ADDR_AX1P, 16'h5A3C);
      idle(6);
      check("word two", axis_write_word_two, 16'h5A3C);
      stat(2'h0, 1'b0);
      $display("test reset done");
      cmd(bp_interp_pkg::CMD_WR_EN);
      for (int k = 0; k < 4; k++) begin
         push_rand(1'b1);
         stat(2'(k < 3 ? k + 1 : 3), 1'b0);
      end
      cmd(bp_interp_pkg::CMD_BP3);
      stat(2'h3, 1'b1);
      pulses(32);
      stat(2'h1, 1'b1);
      check("irq oe", {15'h0000, irq_out_oe}, 16'h0001);
      check("irq n", {15'h0000, irq_out_n}, 16'h0000);
      axis_assign_mode_word = 16'h0000;
      idle(2);
      check("irq oe masked", {15'h0000, irq_out_oe}, 16'h0000);
      axis_assign_mode_word = 16'h8000;
      idle(2);
      check("irq oe", {15'h0000, irq_out_oe}, 16'h0001);
      push_rand(1'b1);
      stat(2'h2, 1'b1);
      check("irq oe", {15'h0000, irq_out_oe}, 16'h0000);
      pulses(16);
      check("irq oe", {15'h0000, irq_out_oe}, 16'h0001);
      cmd(bp_interp_pkg::CMD_IRQ_CLR);
      check("irq oe", {15'h0000, irq_out_oe}, 16'h0000);
      pulses(18);
      stat(2'h0, 1'b0);
      check("irq oe", {15'h0000, irq_out_oe}, 16'h0000);
      $display("test queue run done");
      cmd(bp_interp_pkg::CMD_CLEAR);
      mq.delete();
      bi = 0;
      push_set({16'h0000, 16'h0005, 16'h000F, 48'h0000_0000_0008});
      push_rand(1'b0);
      cmd(bp_interp_pkg::CMD_BP2);
      pulses(3);
      mq.delete();
      bi = 0;
      pulses(1);
      stat(2'h0, 1'b0);
      pulses(1);
      $display("test end code done");
      cmd(bp_interp_pkg::CMD_CLEAR);
      stat(2'h0, 1'b0);
      push_rand(1'b0);
      cmd(bp_interp_pkg::CMD_BP2);
      pulses(2);
      stop_cmd = 1'b1;
      idle(6);
      stat(2'h1, 1'b0);
      stop_cmd = 1'b0;
      run = 1'b0;
      pulses(1);
      run = 1'b1;
      cmd(bp_interp_pkg::CMD_BP2);
      pulses(2);
      stat(2'h1, 1'b1);
      limit_plus = 3'h2;
      idle(6);
      stat(2'h1, 1'b0);
      cmd(bp_interp_pkg::CMD_BP2);
      stat(2'h1, 1'b0);
      limit_plus = 3'h0;
      cmd(bp_interp_pkg::CMD_CLEAR);
      stat(2'h0, 1'b0);
      cmd(bp_interp_pkg::CMD_WR_DIS);
      wr(bp_interp_pkg::ADDR_AX1P, 16'hC3A5);
      idle(6);
      check("word two", axis_write_word_two, 16'hC3A5);
      $display("test stop and limit done");
      finish_test();
   end
endmodule
`default_nettype wire
